//--- include/dgc_regs.vh
// register offsets, field positions and reset values of the dma global control block
`ifndef DGC_REGS_VH
`define DGC_REGS_VH

`define DGC_ADDR_W          9
`define DGC_OFF_GCFG        9'h000
`define DGC_OFF_EN          9'h004
`define DGC_OFF_SREQ        9'h008
`define DGC_OFF_CREQ        9'h00c
`define DGC_OFF_LAST        9'h010
`define DGC_OFF_IER         9'h018
`define DGC_OFF_IDR         9'h01c
`define DGC_OFF_IMR         9'h020
`define DGC_OFF_ISR         9'h024
`define DGC_OFF_WPMR        9'h1e4
`define DGC_BIT_ARB         4
`define DGC_BIT_ENABLE      0
`define DGC_BIT_WRITE_PROTECT_ON        0
`define DGC_GCFG_RESET      1'b1
`define DGC_IRQ_W           24
`define DGC_NCH             8

`endif

//--- verilog/dgc_top.v
// dma global control, software request and interrupt register group
`timescale 1ns/1ps
`default_nettype none
`include "dgc_regs.vh"

module dgc_top
(
	input  wire        i_sys_clk,
	input  wire        i_reset_n,
	input  wire [8:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	input  wire [7:0]  i_buffer_done,
	input  wire [7:0]  i_chain_done,
	input  wire [7:0]  i_bus_fault,
	input  wire [15:0] i_req_taken,
	output reg         o_arbitration_policy,
	output reg         o_ctrl_enable,
	output reg  [15:0] o_single_req,
	output reg  [15:0] o_chunk_req,
	output reg  [15:0] o_final_flag,
	output reg  [7:0]  o_descriptor_stop,
	output reg         o_irq
);

	// decoded write strobes, one per writable register (none for the read-only mask view)
	wire        hit_gcfg;
	wire        hit_en;
	wire        hit_sreq;
	wire        hit_creq;
	wire        hit_last;
	wire        hit_ier;
	wire        hit_idr;
	wire        hit_isr;
	wire        hit_wpmr;
	wire        wr_gcfg;
	wire        wr_en;

	// request set bits and their next values
	wire [15:0] set_single;
	wire [15:0] set_chunk;
	wire [15:0] set_final;
	wire [15:0] next_single_req;
	wire [15:0] next_chunk_req;
	wire [15:0] next_final_flag;

	// mask set and clear bits per event field
	wire [7:0]  mset_buffer;
	wire [7:0]  mset_chain;
	wire [7:0]  mset_fault;
	wire [7:0]  mclr_buffer;
	wire [7:0]  mclr_chain;
	wire [7:0]  mclr_fault;
	wire [7:0]  next_mask_buffer;
	wire [7:0]  next_mask_chain;
	wire [7:0]  next_mask_fault;

	// status clear bits per event field
	wire [7:0]  sclr_buffer;
	wire [7:0]  sclr_chain;
	wire [7:0]  sclr_fault;
	wire [7:0]  next_status_buffer;
	wire [7:0]  next_status_chain;
	wire [7:0]  next_status_fault;

	// per-event fields of mask and status
	reg  [7:0]  mask_buffer;
	reg  [7:0]  mask_chain;
	reg  [7:0]  mask_fault;
	reg  [7:0]  status_buffer;
	reg  [7:0]  status_chain;
	reg  [7:0]  status_fault;
	wire [23:0] irq_mask;
	wire [23:0] irq_status;
	wire [23:0] irq_pending;
	reg         write_protect_on;
	reg  [31:0] next_rdata;

	// one-cycle write strobe aimed at one register offset
	function wr_hit;
		input       wr;
		input [8:0] addr;
		input [8:0] offset;
		begin
			wr_hit = wr && (addr == offset);
		end
	endfunction

	// request update: taken bits drop, new sets win
	function [15:0] req_next;
		input [15:0] current;
		input [15:0] taken;
		input [15:0] set_bits;
		begin
			req_next = (current & ~taken) | set_bits;
		end
	endfunction

	// sticky field update: clear by ones, then sets win
	function [7:0] field_next;
		input [7:0] current;
		input [7:0] clear_bits;
		input [7:0] set_bits;
		begin
			field_next = (current & ~clear_bits) | set_bits;
		end
	endfunction

	// register selects for this cycle's write
	assign hit_gcfg = wr_hit(i_wr, i_addr, `DGC_OFF_GCFG);
	assign hit_en   = wr_hit(i_wr, i_addr, `DGC_OFF_EN);
	assign hit_sreq = wr_hit(i_wr, i_addr, `DGC_OFF_SREQ);
	assign hit_creq = wr_hit(i_wr, i_addr, `DGC_OFF_CREQ);
	assign hit_last = wr_hit(i_wr, i_addr, `DGC_OFF_LAST);
	assign hit_ier  = wr_hit(i_wr, i_addr, `DGC_OFF_IER);
	assign hit_idr  = wr_hit(i_wr, i_addr, `DGC_OFF_IDR);
	assign hit_isr  = wr_hit(i_wr, i_addr, `DGC_OFF_ISR);
	assign hit_wpmr = wr_hit(i_wr, i_addr, `DGC_OFF_WPMR);

	// protected writes pass only while protection is off
	assign wr_gcfg = hit_gcfg && !write_protect_on;
	assign wr_en   = hit_en && !write_protect_on;

	// request bits carried by this cycle's write
	assign set_single = hit_sreq ? i_wdata[15:0] : 16'h0000;
	assign set_chunk  = hit_creq ? i_wdata[15:0] : 16'h0000;
	assign set_final  = hit_last ? i_wdata[15:0] : 16'h0000;

	// request next values; a taken bit is dropped
	assign next_single_req = req_next(o_single_req, i_req_taken, set_single);
	assign next_chunk_req  = req_next(o_chunk_req, i_req_taken, set_chunk);
	assign next_final_flag = req_next(o_final_flag, i_req_taken, set_final);

	// mask sets from the enable-set register
	assign mset_buffer = hit_ier ? i_wdata[7:0] : 8'h00;
	assign mset_chain  = hit_ier ? i_wdata[15:8] : 8'h00;
	assign mset_fault  = hit_ier ? i_wdata[23:16] : 8'h00;

	// mask clears from the enable-clear register
	assign mclr_buffer = hit_idr ? i_wdata[7:0] : 8'h00;
	assign mclr_chain  = hit_idr ? i_wdata[15:8] : 8'h00;
	assign mclr_fault  = hit_idr ? i_wdata[23:16] : 8'h00;

	// mask next values
	assign next_mask_buffer = field_next(mask_buffer, mclr_buffer, mset_buffer);
	assign next_mask_chain  = field_next(mask_chain, mclr_chain, mset_chain);
	assign next_mask_fault  = field_next(mask_fault, mclr_fault, mset_fault);

	// status clears by writing ones to the status register
	assign sclr_buffer = hit_isr ? i_wdata[7:0] : 8'h00;
	assign sclr_chain  = hit_isr ? i_wdata[15:8] : 8'h00;
	assign sclr_fault  = hit_isr ? i_wdata[23:16] : 8'h00;

	// status next values; a same-cycle event beats the clear
	assign next_status_buffer = field_next(status_buffer, sclr_buffer, i_buffer_done);
	assign next_status_chain  = field_next(status_chain, sclr_chain, i_chain_done);
	assign next_status_fault  = field_next(status_fault, sclr_fault, i_bus_fault);

	// gathered views of the per-event fields
	assign irq_mask    = {mask_fault, mask_chain, mask_buffer};
	assign irq_status  = {status_fault, status_chain, status_buffer};
	assign irq_pending = irq_status & irq_mask;

	// arbitration policy, protected
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_arbitration_policy <= `DGC_GCFG_RESET;
		end
		else if (wr_gcfg)
		begin
			o_arbitration_policy <= i_wdata[`DGC_BIT_ARB];
		end
	end

	// controller-wide enable, protected
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_ctrl_enable <= 1'b0;
		end
		else if (wr_en)
		begin
			o_ctrl_enable <= i_wdata[`DGC_BIT_ENABLE];
		end
	end

	// write protection switch, never itself protected
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			write_protect_on <= 1'b0;
		end
		else if (hit_wpmr)
		begin
			write_protect_on <= i_wdata[`DGC_BIT_WRITE_PROTECT_ON];
		end
	end

	// single requests held until the channel takes them
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_single_req <= 16'h0000;
		end
		else
		begin
			o_single_req <= next_single_req;
		end
	end

	// chunk requests held until the channel takes them
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_chunk_req <= 16'h0000;
		end
		else
		begin
			o_chunk_req <= next_chunk_req;
		end
	end

	// final flags, dropped once their request is taken
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_final_flag <= 16'h0000;
		end
		else
		begin
			o_final_flag <= next_final_flag;
		end
	end

	// buffer-done mask byte
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mask_buffer <= 8'h00;
		end
		else
		begin
			mask_buffer <= next_mask_buffer;
		end
	end

	// chain-done mask byte
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mask_chain <= 8'h00;
		end
		else
		begin
			mask_chain <= next_mask_chain;
		end
	end

	// bus-fault mask byte
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			mask_fault <= 8'h00;
		end
		else
		begin
			mask_fault <= next_mask_fault;
		end
	end

	// buffer-done status byte
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			status_buffer <= 8'h00;
		end
		else
		begin
			status_buffer <= next_status_buffer;
		end
	end

	// chain-done status byte
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			status_chain <= 8'h00;
		end
		else
		begin
			status_chain <= next_status_chain;
		end
	end

	// bus-fault status byte
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			status_fault <= 8'h00;
		end
		else
		begin
			status_fault <= next_status_fault;
		end
	end

	// descriptor fetch stop, sticky until reset
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_descriptor_stop <= 8'h00;
		end
		else
		begin
			o_descriptor_stop <= o_descriptor_stop | i_chain_done;
		end
	end

	// level interrupt, one cycle behind status and mask
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_irq <= 1'b0;
		end
		else
		begin
			o_irq <= |irq_pending;
		end
	end

	// read mux
	always @*
	begin
		next_rdata = 32'h00000000;
		case (i_addr)
			`DGC_OFF_GCFG: next_rdata[`DGC_BIT_ARB] = o_arbitration_policy;
			`DGC_OFF_EN:   next_rdata[0] = o_ctrl_enable;
			`DGC_OFF_SREQ: next_rdata[15:0] = o_single_req;
			`DGC_OFF_CREQ: next_rdata[15:0] = o_chunk_req;
			`DGC_OFF_LAST: next_rdata[15:0] = o_final_flag;
			`DGC_OFF_IMR:  next_rdata[23:0] = irq_mask;
			`DGC_OFF_ISR:  next_rdata[23:0] = irq_status;
			`DGC_OFF_WPMR: next_rdata[0] = write_protect_on;
			default:       next_rdata = 32'h00000000;
		endcase
	end

	// read data stands one cycle after the strobe only
	always @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_rdata <= 32'h00000000;
		else
			o_rdata <= i_rd ? next_rdata : 32'h00000000;
	end

endmodule // dgc_top
`default_nettype wire

//--- test/dgc_top_monitor.sv
// port checker for the dma global control block
`timescale 1ns/1ps
`default_nettype none
module dgc_top_monitor
(
	input wire logic        i_sys_clk, i_reset_n, i_wr, i_rd, o_arbitration_policy, o_ctrl_enable,
	input wire logic        o_irq,
	input wire logic [8:0]  i_addr,
	input wire logic [31:0] i_wdata, o_rdata,
	input wire logic [7:0]  i_buffer_done, i_chain_done, i_bus_fault, o_descriptor_stop,
	input wire logic [15:0] o_single_req, o_chunk_req
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not idle");
	chk_arb_hold: assert property (!(i_wr && i_addr == 9'h000) |=> $stable(o_arbitration_policy))
		else $error("policy moved without write");
	chk_en_hold: assert property (!(i_wr && i_addr == 9'h004) |=> $stable(o_ctrl_enable))
		else $error("enable moved without write");
	chk_sreq_set: assert property (i_wr && i_addr == 9'h008 |=> &(o_single_req | ~$past(i_wdata[15:0])))
		else $error("single request not set");
	chk_creq_set: assert property (i_wr && i_addr == 9'h00c |=> &(o_chunk_req | ~$past(i_wdata[15:0])))
		else $error("chunk request not set");
	chk_stop_set: assert property (|i_chain_done |=> &(o_descriptor_stop | ~$past(i_chain_done)))
		else $error("fetch stop not set");
	chk_stop_keep: assert property (o_descriptor_stop[0] |=> o_descriptor_stop[0])
		else $error("fetch stop dropped");
	chk_irq_cause: assert property ($rose(o_irq) |->
		$past(i_wr, 2) || $past(|{i_buffer_done, i_chain_done, i_bus_fault}, 2))
		else $error("interrupt without cause");
endmodule // dgc_top_monitor
bind dgc_top dgc_top_monitor u_mon (.*);
`default_nettype wire

//--- test/dgc_top_tb_top.sv
// self-checking bench for the dma global control block
`timescale 1ns/1ps
`default_nettype none
module dgc_top_tb_top;
	logic c = 0, rn = 0, wr = 0, rd = 0, irq;
	logic [8:0] a = 0;
	logic [31:0] wd = 0, rdat, m, d;
	logic [7:0] bd = 0, cd = 0, bf = 0;
	logic [15:0] tk = 0, sq, cq, ff;
	logic pol, en;
	logic [7:0] st;
	integer seed = 32'hb4f756e2;
	int err_count = 0, comparisons = 0, j;
	dgc_top dut (.i_sys_clk(c), .i_reset_n(rn), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdat), .i_buffer_done(bd), .i_chain_done(cd), .i_bus_fault(bf), .i_req_taken(tk),
		.o_arbitration_policy(pol), .o_ctrl_enable(en), .o_single_req(sq), .o_chunk_req(cq),
		.o_final_flag(ff), .o_descriptor_stop(st), .o_irq(irq));
	initial forever #5 c = ~c;
	task tally_and_finish;
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task k(input [31:0] g, e);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one-cycle write, then one-cycle read checked in the following cycle
	task w(input [8:0] ad, input [31:0] v);
		@(posedge c) begin wr <= 1; a <= ad; wd <= v; end
		@(posedge c) wr <= 0;
	endtask
	task r(input [8:0] ad, input [31:0] e);
		@(posedge c) begin rd <= 1; a <= ad; end
		@(posedge c) rd <= 0;
		#1 k(rdat, e);
	endtask
	initial
	begin
		#200000 err_count++;
		tally_and_finish;
	end
	initial
	begin
		m = $random(seed) & 32'hffffff;
		d = $random(seed);
		repeat (6) @(posedge c);
		rn <= 1;
		r(9'h000, 32'h10);
		w(9'h000, 0); r(9'h000, 0); k(pol, 0);
		r(9'h004, 0); w(9'h004, 1); r(9'h004, 1); k(en, 1);
		w(9'h1e4, 1); w(9'h004, 0); r(9'h004, 1); w(9'h1e4, 0);
		w(9'h018, m); r(9'h020, m);
		w(9'h01c, d); r(9'h020, m & ~d & 32'hffffff);
		w(9'h01c, 32'hffffff); r(9'h020, 0);
		@(posedge c) begin bd <= 1; cd <= 2; bf <= 4; end
		@(posedge c) begin bd <= 0; cd <= 0; bf <= 0; end
		r(9'h024, 32'h040201); k(irq, 0);
		k(st, 8'h02);
		w(9'h018, 32'h200); @(posedge c); #1 k(irq, 1);
		w(9'h024, 32'h200); r(9'h024, 32'h040001); k(irq, 0);
		for (j = 0; j < 3; j++)
		begin
			w(9'(8 + 4 * j), d & 32'hffff); r(9'(8 + 4 * j), d & 32'hffff);
		end
		k(sq, d & 32'hffff); k(cq, d & 32'hffff); k(ff, d & 32'hffff);
		@(posedge c) tk <= 16'hffff;
		@(posedge c) tk <= 0;
		r(9'h008, 0); r(9'h00c, 0); r(9'h010, 0); k(sq, 0);
		tally_and_finish;
	end
endmodule // dgc_top_tb_top
`default_nettype wire
